// [hw/ddc_port.v]
// Serial command port and register control of a dual 12-bit converter.
//
// What this block does
// [R1] Host sends each command as 16 bits, chip select low throughout.
// [R2] Clock and data are ignored while chip select is high.
// [R3] Serial input shifts in on each rising serial clock edge while selected.
// [R4] Rising chip select transfers the word into input and converter registers.
// [R5] Host keeps the serial clock at or below 10 MHz.
// [R6] Load input only, copy input to converter, or load both.
// [R7] Select and command bits pick registers, output edge, user output, power.
// [R8] Serial output comes from the shift register's last stage on falling edges, from the stage before it on rising edges.
// [R9] Falling-edge mode: output changes on falling edges, 16-cycle lag.
// [R10] Rising-edge mode: output changes on rising edges, 15.5-cycle lag.
// [R11] Falling-edge output mode is selected after power-up.
// [R12] User logic output set only by commands, low after power-up.
// [R13] Shutdown commands are ignored while the lockout input is low.
// [R14] Lockout falling while powered down wakes the channels without serial clock.
// [R15] Chained devices feed serial output to the next device's input.
// [R16] Devices on a shared data line each get their own chip select.
// [R17] Power-up clears all input and converter registers to zero.
// [R18] Code is unsigned straight binary, followed by a zero pad bit.
// [R19] Decode the three select and command bits into load and update actions.
// [R20] All-zero select and command makes the top code bits a subcommand.
// [R21] Power-down keeps the interface and input data; updates wake a channel.
// [R22] Host always sends the pad bit as zero.
// [R23] Frames go most significant bit first: select, command, code, pad.
`default_nettype none
`include "ddc_defs.vh"
module ddc_port #(
  parameter CW = `DDC_CODE_BITS,
  parameter FW = `DDC_FRAME_BITS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire serial_clk,
  input wire serial_din,
  input wire chip_select_n,
  input wire powerdown_lockout_n,
  output reg serial_dout,
  output reg user_logic_out,
  output reg [CW-1:0] conv_code_a,
  output reg [CW-1:0] conv_code_b,
  output reg powered_down_a,
  output reg powered_down_b,
  output reg [CW-1:0] input_code_a,
  output reg [CW-1:0] input_code_b,
  output reg output_edge_rising
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  wire [3:0] pins_s;
  ddc_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({serial_clk, serial_din, chip_select_n, powerdown_lockout_n}),
    .rst_val(4'h3), // Idle: clock low, data low, deselected, unlocked.
    .sync_out(pins_s)
  );
  wire sclk_s = pins_s[3];
  wire din_s = pins_s[2];
  wire csn_s = pins_s[1];
  wire lock_n_s = pins_s[0];

  reg sclk_d_r;
  reg csn_d_r;
  reg lock_d_r;
  reg [FW-1:0] shift_r;
  reg [FW-1:0] shift_nxt;
  reg csn_init_r;

  // Edge history; chip select remembers high after reset so no spurious frame end.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sclk_d_r <= 1'b0;
      csn_d_r <= 1'b1;
      lock_d_r <= 1'b1;
      csn_init_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      csn_d_r <= csn_s;
      lock_d_r <= lock_n_s;
      csn_init_r <= 1'b1;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  // A frame ends on the rising chip select edge, once the history is valid.
  wire frame_end = csn_s & ~csn_d_r & csn_init_r;
  // Lockout falling edge, used for the clockless-style wake.
  wire lock_fall = ~lock_n_s & lock_d_r;

  // ****************************************
  // Shift register
  // ****************************************
  // Shifting in at the bottom keeps the first bit, the select bit, at the top.
  always @*
  begin
    shift_nxt = shift_r;
    // [R2] [R3] selected rising shift
    if (!csn_s && sclk_rise)
      shift_nxt = {shift_r[FW-2:0], din_s};
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      shift_r <= {FW{1'b0}};
    else
      shift_r <= shift_nxt;
  end

  // ****************************************
  // Serial output
  // ****************************************
  // Rising-edge mode shows the stage before the last one instead of the last stage, so the
  // lag is 16 cycles on falling edges and half a cycle less on rising edges.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      serial_dout <= 1'b0;
    // [R8] [R10] rising edge output
    else if (output_edge_rising && sclk_rise && !csn_s)
      serial_dout <= shift_r[FW-2];
    // [R8] [R9] falling edge output
    else if (!output_edge_rising && sclk_fall && !csn_s)
      serial_dout <= shift_r[FW-1];
  end

  // ****************************************
  // Command decode and registers
  // ****************************************
  // [R23] [R18] frame field split
  wire [2:0] op = shift_r[`DDC_SEL_BIT:`DDC_CMD_LO];
  wire [CW-1:0] code = shift_r[`DDC_CODE_HI:`DDC_CODE_LO];
  wire [2:0] sub = shift_r[`DDC_SUB_HI:`DDC_SUB_HI-2];
  wire sub_mode = shift_r[`DDC_SUB_LO];
  wire lock_active = ~lock_n_s;

  // The pad bit is not checked; a host that breaks it still gets its command.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // [R17] [R11] [R12] power-up clear
      input_code_a <= `DDC_CODE_RST;
      input_code_b <= `DDC_CODE_RST;
      conv_code_a <= `DDC_CODE_RST;
      conv_code_b <= `DDC_CODE_RST;
      powered_down_a <= 1'b0;
      powered_down_b <= 1'b0;
      user_logic_out <= `DDC_UOUT_RST;
      output_edge_rising <= `DDC_EDGE_RST;
    end
    // [R4] [R7] [R19] [R6] frame end decode
    else if (frame_end)
    begin
      case (op)
        `DDC_OP_LD_IN_A:
          input_code_a <= code;
        `DDC_OP_LD_IN_B:
          input_code_b <= code;
        `DDC_OP_LD_IN_A_UPD:
        begin
          // [R21] update wakes both
          input_code_a <= code;
          conv_code_a <= code;
          conv_code_b <= input_code_b;
          powered_down_a <= 1'b0;
          powered_down_b <= 1'b0;
        end
        `DDC_OP_LD_IN_B_UPD:
        begin
          input_code_b <= code;
          conv_code_b <= code;
          conv_code_a <= input_code_a;
          powered_down_a <= 1'b0;
          powered_down_b <= 1'b0;
        end
        `DDC_OP_LD_BOTH_CONV:
        begin
          conv_code_a <= code;
          conv_code_b <= code;
          powered_down_a <= 1'b0;
          powered_down_b <= 1'b0;
        end
        `DDC_OP_UPD_BOTH:
        begin
          conv_code_a <= input_code_a;
          conv_code_b <= input_code_b;
          powered_down_a <= 1'b0;
          powered_down_b <= 1'b0;
        end
        `DDC_OP_SHDN_BOTH:
        begin
          // [R13] lockout blocks shutdown
          if (!lock_active)
          begin
            powered_down_a <= 1'b1;
            powered_down_b <= 1'b1;
          end
        end
        default:
        begin
          // [R20] subcommand decode
          case (sub)
            `DDC_SUB_UPD_A:
            begin
              conv_code_a <= input_code_a;
              powered_down_a <= 1'b0;
            end
            `DDC_SUB_UPD_B:
            begin
              conv_code_b <= input_code_b;
              powered_down_b <= 1'b0;
            end
            `DDC_SUB_PD_A:
              if (!lock_active)
                powered_down_a <= 1'b1;
            `DDC_SUB_PD_B:
              if (!lock_active)
                powered_down_b <= 1'b1;
            `DDC_SUB_OUT_LO:
              user_logic_out <= 1'b0;
            `DDC_SUB_OUT_HI:
              user_logic_out <= 1'b1;
            `DDC_SUB_EDGE:
              output_edge_rising <= sub_mode;
            default:
              user_logic_out <= user_logic_out;
          endcase
        end
      endcase
    end
    // [R14] lockout wake
    // Kept apart from the frame decode so a wake that lands on a frame end is not lost.
    if (rst_n && lock_fall)
    begin
      powered_down_a <= 1'b0;
      powered_down_b <= 1'b0;
    end
  end
endmodule // ddc_port
`default_nettype wire

// [hw/ddc_defs.vh]
// Constants for the dual converter serial command port.
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH
// Frame layout, most significant bit first.
`define DDC_FRAME_BITS 16
`define DDC_CODE_BITS 12
`define DDC_SEL_BIT 15
`define DDC_CMD_HI 14
`define DDC_CMD_LO 13
`define DDC_CODE_HI 12
`define DDC_CODE_LO 1
`define DDC_SUB_HI 12
`define DDC_SUB_LO 9
// Channel-select and command field values.
`define DDC_OP_SUB 3'h0
`define DDC_OP_LD_IN_A 3'h1
`define DDC_OP_LD_IN_A_UPD 3'h2
`define DDC_OP_LD_BOTH_CONV 3'h3
`define DDC_OP_UPD_BOTH 3'h4
`define DDC_OP_LD_IN_B 3'h5
`define DDC_OP_LD_IN_B_UPD 3'h6
`define DDC_OP_SHDN_BOTH 3'h7
// Subcommand top three bits, with the mode bit separate.
`define DDC_SUB_NOP 3'h0
`define DDC_SUB_UPD_A 3'h1
`define DDC_SUB_OUT_LO 3'h2
`define DDC_SUB_OUT_HI 3'h3
`define DDC_SUB_EDGE 3'h4
`define DDC_SUB_UPD_B 3'h5
`define DDC_SUB_PD_A 3'h6
`define DDC_SUB_PD_B 3'h7
// Reset values.
`define DDC_CODE_RST 12'h000
`define DDC_EDGE_RST 1'b0
`define DDC_UOUT_RST 1'b0
`endif

// [hw/ddc_sync.v]
// Two-stage synchroniser for a group of pin inputs.
`default_nettype none
module ddc_sync #(
  parameter W = 3
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  input wire [W-1:0] rst_val,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_r;

  // The first stage feeds only the second stage, never any logic.
  always @(posedge ref_clk)
  begin
    // Both stages reset to the pins' idle levels, so that no false edge follows reset.
    if (!rst_n)
    begin
      meta_r <= rst_val;
      sync_out <= rst_val;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // ddc_sync
`default_nettype wire

// [dv/ddc_port_sva.sv]
// Port assertions for the converter command port.
`default_nettype none
module ddc_port_sva #(
  parameter CW = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_din,
  input wire logic chip_select_n,
  input wire logic powerdown_lockout_n,
  input wire logic serial_dout,
  input wire logic user_logic_out,
  input wire logic [CW-1:0] conv_code_a,
  input wire logic [CW-1:0] conv_code_b,
  input wire logic powered_down_a,
  input wire logic powered_down_b,
  input wire logic [CW-1:0] input_code_a,
  input wire logic [CW-1:0] input_code_b,
  input wire logic output_edge_rising
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Checks
  // ****
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RST_CLEAR:
    assert property ($rose(rst_n) |-> !(|{conv_code_a, conv_code_b, input_code_a,
      input_code_b, user_logic_out, output_edge_rising})) else $error("Bad reset value");
  AST_DOUT_IDLE:
    assert property (chip_select_n [*8] |=> $stable(serial_dout)) else $error("Idle dout");
  AST_IN_AT_CS:
    assert property ($changed({input_code_a, input_code_b}) |-> chip_select_n)
      else $error("Input reg moved in frame");
  AST_CONV_AT_CS:
    assert property ($changed({conv_code_a, conv_code_b}) |-> chip_select_n)
      else $error("Conv reg moved in frame");
  AST_CTRL_AT_CS:
    assert property ($changed({user_logic_out, output_edge_rising}) |-> chip_select_n)
      else $error("Control moved in frame");
  AST_PD_ENTRY:
    assert property ($rose(powered_down_a) || $rose(powered_down_b) |->
      chip_select_n && powerdown_lockout_n) else $error("Bad power down");
  AST_LOCKED:
    assert property (!powerdown_lockout_n [*8] |=> !(powered_down_a || powered_down_b))
      else $error("Down while locked");
  AST_WAKE:
    assert property ($fell(powerdown_lockout_n) |-> ##[1:6] !(powered_down_a ||
      powered_down_b)) else $error("No wake");
  // The output moves in the clock phase that follows the chosen edge.
  AST_DOUT_EDGE:
    assert property ($changed(serial_dout) |-> (serial_clk == output_edge_rising))
      else $error("Dout moved on wrong edge");
endmodule // ddc_port_sva
bind ddc_port ddc_port_sva #(.CW(CW)) i_sva (.*);
`default_nettype wire

// [dv/ddc_host_model.sv]
// Host serial master model for the command port pins.
`default_nettype none
module ddc_host_model (
  input wire logic ref_clk,
  input wire logic serial_dout,
  output logic serial_clk,
  output logic serial_din,
  output logic chip_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Master
  // ****
  logic [15:0] rb;
  // Clock rests low outside frames; chip select starts high.
  initial
  begin
    {serial_clk, serial_din, chip_select_n, rb} = {3'b001, 16'h0000};
  end
  // released data toggles
  // A stale bit must never look valid while deselected.
  always @(posedge ref_clk)
    if (chip_select_n)
      serial_din <= ~serial_din;
  // frame of 16
  // Bit period 160 ns; split pauses between two 8-bit packets.
  task automatic send(input logic [15:0] w, input bit split);
    @(posedge ref_clk);
    #2 chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_din = w[i];
      if (split && i == 7)
        #400;
      #80 rb = {rb[14:0], serial_dout}; // Read back just before the rise.
      serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    #80 chip_select_n = 1'b1;
    #200;
  endtask
endmodule // ddc_host_model
`default_nettype wire

// [dv/ddc_port_bench.sv]
// Self-checking bench for the converter command port.
`default_nettype none
module ddc_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Bench
  // ****
  logic ref_clk, rst_n, powerdown_lockout_n, pa, pb, uo, er;
  wire serial_clk, serial_din, chip_select_n, serial_dout, user_logic_out;
  wire powered_down_a, powered_down_b, output_edge_rising;
  wire [11:0] input_code_a, input_code_b, conv_code_a, conv_code_b;
  logic [11:0] ia, ib, ca, cb;
  logic [15:0] prev, rbx;
  logic [67:0] exp_q[$];
  logic [67:0] e;
  int bad_count = 0, checks_done = 0;
  integer seed = 32'h6689;
  ddc_port i_dut (.*);
  ddc_host_model i_host (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    // Frames whose results were never compared count together as one mismatch.
    if (exp_q.size() != 0)
    begin
      bad_count++;
      $display("ERROR %0t %0d frame results never checked", $time, exp_q.size());
    end
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Notes the expected state, then sends the frame; pad is zero.
  task automatic frame(input logic [2:0] op, input logic [11:0] d, input bit sp);
    logic [15:0] w;
    w = {op, d, 1'b0};
    // readback lag
    // The host samples just before each rise, so both modes hand back the whole last word.
    rbx = prev;
    prev = w;
    case (op)
      3'h1: ia = d;
      3'h5: ib = d;
      3'h2: {ia, ca, cb, pa, pb} = {d, d, ib, 2'b00};
      3'h6: {ib, ca, cb, pa, pb} = {d, ia, d, 2'b00};
      3'h3: {ca, cb, pa, pb} = {d, d, 2'b00};
      3'h4: {ca, cb, pa, pb} = {ia, ib, 2'b00};
      3'h7: {pa, pb} = {pa, pb} | {2{powerdown_lockout_n}};
      default: case (d[11:9])
        3'h1: {ca, pa} = {ia, 1'b0};
        3'h5: {cb, pb} = {ib, 1'b0};
        3'h6: pa = pa | powerdown_lockout_n;
        3'h7: pb = pb | powerdown_lockout_n;
        3'h2: uo = 1'b0;
        3'h3: uo = 1'b1;
        3'h4: er = d[8];
        default: ;
      endcase
    endcase
    exp_q.push_back({ia, ib, ca, cb, pa, pb, uo, er, rbx});
    i_host.send(w, sp);
  endtask
  // Each chip select rise yields one result, settled 8 cycles on.
  initial
  begin
    @(posedge rst_n);
    forever
    begin
      @(posedge chip_select_n);
      repeat (8) @(posedge ref_clk);
      e = exp_q.pop_front();
      checks_done++;
      if (e !== {input_code_a, input_code_b, conv_code_a, conv_code_b, powered_down_a,
        powered_down_b, user_logic_out, output_edge_rising, i_host.rb})
        begin
          bad_count++;
          $display("ERROR %0t frame result, expected %h", $time, e);
        end
    end
  end
  initial
  begin
    {rst_n, pa, pb, uo, er} = 5'h00;
    powerdown_lockout_n = 1'b1;
    {ia, ib, ca, cb} = 48'h000000000000;
    prev = 16'h0000;
    repeat (10) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    frame(3'h3, 12'hFFF, 1'b0);
    for (int i = 1; i < 8; i++)
      frame(i[2:0], 12'($random(seed)), i == 3);
    for (int i = 0; i < 16; i++)
      frame(3'h0, {i[3:0], 8'($random(seed))}, 1'b0);
    $display("Test done: command decode");
    frame(3'h4, 12'h000, 1'b0);
    @(posedge ref_clk);
    #2 powerdown_lockout_n = 1'b0;
    frame(3'h7, 12'h000, 1'b0);
    frame(3'h0, 12'hC00, 1'b0);
    powerdown_lockout_n = 1'b1;
    frame(3'h7, 12'($random(seed)), 1'b0);
    @(posedge ref_clk);
    #2 powerdown_lockout_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    checks_done++;
    if ({powered_down_a, powered_down_b} !== 2'b00)
    begin
      bad_count++;
      $display("ERROR %0t lockout did not wake", $time);
    end
    $display("Test done: lockout");
    finish_test();
  end
endmodule // ddc_port_bench
`default_nettype wire
